// File: inc/ldm_pkg.sv
// Constants for the dimming mode control block: timing, levels and states.
// Assumes a 100 MHz system clock; the analog side reads the reference code.
package ldm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DETECT_DELAY_US = 100;
  localparam int unsigned LOW_DETECT_US = 260;
  localparam int unsigned DETECT_WINDOW_US = 1000;
  localparam int unsigned SHUTDOWN_US = 2500;
  // Least times round up, longest times round down; all are whole microseconds here.
  localparam int unsigned DETECT_DELAY_CYC = DETECT_DELAY_US * CLK_MHZ;
  localparam int unsigned LOW_DETECT_CYC = LOW_DETECT_US * CLK_MHZ + 1;
  localparam int unsigned DETECT_WINDOW_CYC = DETECT_WINDOW_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_US * CLK_MHZ + 1;
  localparam int unsigned TMR_W = 18;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned REF_W = 8;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 5'h1f;
  localparam logic [REF_W-1:0] REF_FULL_MV = 8'hc8;
  localparam int unsigned AVG_W = 8;
  localparam logic [AVG_W-1:0] AVG_FULL = 8'hff;
  typedef enum logic [3:0] {
    LDM_OFF = 4'h1,
    LDM_DETECT = 4'h2,
    LDM_PWM = 4'h4,
    LDM_WIRE = 4'h8
  } ldm_state_t;
endpackage : ldm_pkg

// File: src/ldm_level_rom.sv
// Maps a 5-bit brightness code to the feedback reference in millivolts.
// Read data are registered; one cycle latency.
`timescale 1ns/100ps
`default_nettype none
module ldm_level_rom (
  input wire logic clk, // System clock.
  input wire logic [ldm_pkg::LEVEL_W-1:0] code, // Brightness code.
  output logic [ldm_pkg::REF_W-1:0] mv_ff // Reference in mV.
);
  import ldm_pkg::*;
  logic [REF_W-1:0] nxt_mv;
  // Steps grow with the code for a near-logarithmic brightness curve.
  always_comb begin
    case (code)
      5'h00: nxt_mv = 8'h00;
      5'h01: nxt_mv = 8'h05;
      5'h02: nxt_mv = 8'h08;
      5'h03: nxt_mv = 8'h0b;
      5'h04: nxt_mv = 8'h0e;
      5'h05: nxt_mv = 8'h11;
      5'h06: nxt_mv = 8'h14;
      5'h07: nxt_mv = 8'h17;
      5'h08: nxt_mv = 8'h1a;
      5'h09: nxt_mv = 8'h1d;
      5'h0a: nxt_mv = 8'h20;
      5'h0b: nxt_mv = 8'h23;
      5'h0c: nxt_mv = 8'h26;
      5'h0d: nxt_mv = 8'h2c;
      5'h0e: nxt_mv = 8'h32;
      5'h0f: nxt_mv = 8'h38;
      5'h10: nxt_mv = 8'h3e;
      5'h11: nxt_mv = 8'h44;
      5'h12: nxt_mv = 8'h4a;
      5'h13: nxt_mv = 8'h50;
      5'h14: nxt_mv = 8'h56;
      5'h15: nxt_mv = 8'h5c;
      5'h16: nxt_mv = 8'h62;
      5'h17: nxt_mv = 8'h68;
      5'h18: nxt_mv = 8'h74;
      5'h19: nxt_mv = 8'h80;
      5'h1a: nxt_mv = 8'h8c;
      5'h1b: nxt_mv = 8'h98;
      5'h1c: nxt_mv = 8'ha4;
      5'h1d: nxt_mv = 8'hb0;
      5'h1e: nxt_mv = 8'hbc;
      default: nxt_mv = 8'hc8;
    endcase
  end
  always_ff @(posedge clk) begin
    mv_ff <= nxt_mv;
  end
endmodule : ldm_level_rom
`default_nettype wire

// File: src/ldm_mode_ctrl.sv
// Dimming mode control: watches the control pin after each enable, picks PWM
// or one-wire mode, and produces the feedback reference code in millivolts.
// Assumes ctrl_pin is synchronous to clk and that an external decoder delivers
// decoded one-wire brightness codes with a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
module ldm_mode_ctrl #(
  parameter int unsigned DELAY_CYC = ldm_pkg::DETECT_DELAY_CYC, // Detect delay.
  parameter int unsigned LOWDET_CYC = ldm_pkg::LOW_DETECT_CYC, // Low-detect time.
  parameter int unsigned WINDOW_CYC = ldm_pkg::DETECT_WINDOW_CYC, // Window length.
  parameter int unsigned SHDN_CYC = ldm_pkg::SHUTDOWN_CYC // Shutdown low time.
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic srst, // Power-on reset, synchronous, active high.
  input wire logic ctrl_pin, // Control pin level.
  input wire logic level_valid, // Decoded brightness command strobe.
  input wire logic [ldm_pkg::LEVEL_W-1:0] level_code, // Decoded brightness code.
  output logic enabled_ff, // Device out of shutdown.
  output logic wire_mode_ff, // One-wire digital mode selected.
  output logic detecting_ff, // Detection window open.
  output logic [ldm_pkg::LEVEL_W-1:0] level_ff, // Stored brightness code.
  output logic [ldm_pkg::REF_W-1:0] feedback_reference_voltage_ff // Reference, mV.
);
  import ldm_pkg::*;

  ldm_state_t state_ff;
  ldm_state_t nxt_state;
  logic pin_d_ff;
  logic [TMR_W-1:0] win_cnt_ff;
  logic [TMR_W-1:0] nxt_win_cnt;
  logic [TMR_W-1:0] low_cnt_ff;
  logic [TMR_W-1:0] nxt_low_cnt;
  logic low_after_delay_ff;
  logic nxt_low_after_delay;
  logic [LEVEL_W-1:0] nxt_level;
  logic [AVG_W-1:0] avg_ff;
  logic [AVG_W+7:0] avg_acc_ff;
  logic [AVG_W+7:0] nxt_avg_acc;
  logic [REF_W-1:0] wire_mv;
  logic [REF_W-1:0] nxt_reference;

  // Pin edges against the previous sample. The sample resets low, the shutdown
  // level of the pin, so a pin already high at reset release counts as an enable.
  wire rise = ctrl_pin & ~pin_d_ff;
  wire fall = ~ctrl_pin & pin_d_ff;

  // Window, delay and low-time decodes, all in clock cycles.
  wire low_qual = low_cnt_ff >= TMR_W'(LOWDET_CYC);
  wire shdn_hit = low_cnt_ff >= TMR_W'(SHDN_CYC);
  wire in_window = win_cnt_ff < TMR_W'(WINDOW_CYC);
  wire delay_done = win_cnt_ff >= TMR_W'(DELAY_CYC);
  // Low time only counts once it began after the detect delay.
  wire entry_ok = low_after_delay_ff & low_qual & in_window & ~ctrl_pin;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LDM_OFF: begin
        if (rise) begin
          nxt_state = LDM_DETECT;
        end
      end
      LDM_DETECT: begin
        if (entry_ok) begin
          nxt_state = LDM_WIRE;
        end else if (!in_window) begin
          nxt_state = LDM_PWM;
        end
      end
      // Either mode stays fixed until a long low forces shutdown.
      LDM_PWM: begin
        if (shdn_hit) begin
          nxt_state = LDM_OFF;
        end
      end
      LDM_WIRE: begin
        if (shdn_hit) begin
          nxt_state = LDM_OFF;
        end
      end
      default: begin
        nxt_state = LDM_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= LDM_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_d_ff <= 1'b0;
    end else begin
      pin_d_ff <= ctrl_pin;
    end
  end

  // Window counter runs from the enabling edge and saturates.
  assign nxt_win_cnt = (state_ff == LDM_OFF) ? '0
                     : in_window ? win_cnt_ff + TMR_W'(1) : win_cnt_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      win_cnt_ff <= '0;
    end else begin
      win_cnt_ff <= nxt_win_cnt;
    end
  end

  // Low-time counter, shared by entry detection and shutdown. It saturates, so a
  // pin parked low in shutdown never wraps back into a short low count.
  assign nxt_low_cnt = ctrl_pin ? '0
                     : shdn_hit ? low_cnt_ff : low_cnt_ff + TMR_W'(1);
  always_ff @(posedge clk) begin
    if (srst) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // A low qualifies only if its falling edge came after the detect delay.
  assign nxt_low_after_delay = ctrl_pin ? 1'b0
                             : fall ? delay_done : low_after_delay_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      low_after_delay_ff <= 1'b0;
    end else begin
      low_after_delay_ff <= nxt_low_after_delay;
    end
  end

  // Commands count only in one-wire mode; in any other state they are dropped.
  // The stored level is set back to LEVEL_FULL only by srst, never by shutdown.
  assign nxt_level = (level_valid && state_ff == LDM_WIRE) ? level_code : level_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      level_ff <= LEVEL_FULL;
    end else begin
      level_ff <= nxt_level;
    end
  end

  ldm_level_rom u_rom (
    .clk(clk),
    .code(level_ff),
    .mv_ff(wire_mv)
  );

  // First-order average of the pin as a logic level; drive voltage plays no part.
  // Settles to duty times full scale with a 256-cycle time constant.
  wire [AVG_W+7:0] avg_in = ctrl_pin ? {AVG_FULL, 8'hff} : '0;
  wire [AVG_W+7:0] avg_step = (avg_in >> 8) - (avg_acc_ff >> 8);
  assign nxt_avg_acc = avg_acc_ff + avg_step;
  always_ff @(posedge clk) begin
    if (srst) begin
      avg_acc_ff <= '0;
    end else begin
      avg_acc_ff <= nxt_avg_acc;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      avg_ff <= '0;
    end else begin
      avg_ff <= avg_acc_ff[AVG_W+7:8];
    end
  end

  // Scale 0..255 to 0..200 mV; full high reads full scale.
  wire [AVG_W+REF_W-1:0] pwm_prod = (AVG_W+REF_W)'(avg_ff) * (AVG_W+REF_W)'(REF_FULL_MV);
  wire [REF_W-1:0] pwm_mv = (avg_ff == AVG_FULL) ? REF_FULL_MV
                           : pwm_prod[AVG_W+REF_W-1:AVG_W];
  // Detection runs on the PWM path, as PWM is the fallback; shutdown reads zero.
  assign nxt_reference = (state_ff == LDM_WIRE) ? wire_mv
                       : (state_ff == LDM_OFF) ? '0 : pwm_mv;

  always_ff @(posedge clk) begin
    if (srst) begin
      enabled_ff <= 1'b0;
      wire_mode_ff <= 1'b0;
      detecting_ff <= 1'b0;
    end else begin
      enabled_ff <= state_ff != LDM_OFF;
      wire_mode_ff <= state_ff == LDM_WIRE;
      detecting_ff <= state_ff == LDM_DETECT;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      feedback_reference_voltage_ff <= '0;
    end else begin
      feedback_reference_voltage_ff <= nxt_reference;
    end
  end
endmodule : ldm_mode_ctrl
`default_nettype wire

// File: dv/ldm_mode_ctrl_assertions.sv
// Checker for the dimming mode control ports.
// Assumes it is bound onto ldm_mode_ctrl and that the pin is low in reset.
`timescale 1ns/100ps
`default_nettype none
module ldm_mode_ctrl_assertions #(
  parameter int unsigned SHDN_CYC = 250 // Shutdown low time.
) (
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic ctrl_pin, // Pin.
  input wire logic level_valid, // Strobe.
  input wire logic [4:0] level_code, // Code.
  input wire logic enabled_ff, // Enabled.
  input wire logic wire_mode_ff, // Wire mode.
  input wire logic detecting_ff, // Window.
  input wire logic [4:0] level_ff, // Level.
  input wire logic [7:0] feedback_reference_voltage_ff // Reference.
);
  logic [19:0] lo_cnt_ff;
  logic [19:0] hi_cnt_ff;
  // Runs of equal pin samples, wide enough for the full-length shutdown count.
  always_ff @(posedge clk) begin
    lo_cnt_ff <= (srst || ctrl_pin) ? 20'h0 : lo_cnt_ff + 20'h1;
    hi_cnt_ff <= (srst || !ctrl_pin) ? 20'h0 : hi_cnt_ff + 20'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_level_full: assert property (disable iff (1'b0) srst |=> level_ff == 5'h1f)
    else $error("level not full after reset");
  a_off_level_kept: assert property (!enabled_ff && level_valid |=> $stable(level_ff))
    else $error("level taken in shutdown");
  a_wire_level_take: assert property (
    wire_mode_ff && level_valid |=> level_ff == $past(level_code))
    else $error("level code not stored");
  a_full_code_ref: assert property (
    (wire_mode_ff && level_ff == 5'h1f) [*3] |-> feedback_reference_voltage_ff == 8'hc8)
    else $error("full code reference wrong");
  a_pwm_full_ref: assert property (
    hi_cnt_ff == 20'h00960 && !wire_mode_ff |-> feedback_reference_voltage_ff == 8'hc8)
    else $error("constant high reference wrong");
  a_window_open: assert property ($rose(ctrl_pin) && !enabled_ff |-> ##2 detecting_ff)
    else $error("window not opened");
  a_shutdown_low: assert property (
    lo_cnt_ff == 20'(SHDN_CYC + 4) |-> !enabled_ff && !wire_mode_ff)
    else $error("no shutdown after long low");
  a_mode_held: assert property (wire_mode_ff && hi_cnt_ff >= 20'h2 |=> wire_mode_ff)
    else $error("wire mode lost while enabled");
endmodule : ldm_mode_ctrl_assertions
bind ldm_mode_ctrl ldm_mode_ctrl_assertions #(.SHDN_CYC(SHDN_CYC)) chk_u (
  .clk(clk), .srst(srst), .ctrl_pin(ctrl_pin), .level_valid(level_valid),
  .level_code(level_code), .enabled_ff(enabled_ff), .wire_mode_ff(wire_mode_ff),
  .detecting_ff(detecting_ff), .level_ff(level_ff),
  .feedback_reference_voltage_ff(feedback_reference_voltage_ff));
`default_nettype wire

// File: dv/ldm_host_model.sv
// Host model: drives the control pin and the decoded level strobe.
// Assumes the caller sequences the timing; all changes land 1 ns after an edge.
`timescale 1ns/100ps
`default_nettype none
module ldm_host_model (
  input wire logic clk, // Clock.
  output logic ctrl_pin, // Pin.
  output logic level_valid, // Strobe.
  output logic [4:0] level_code // Code.
);
  initial begin
    ctrl_pin = 1'b0;
    level_valid = 1'b0;
    level_code = 5'h0;
  end
  // Pin level for n cycles; callers keep PWM lows short of entry timing.
  task automatic drive(input logic lvl, input int n);
    repeat (n) begin
      @(posedge clk);
      #1 ctrl_pin = lvl;
    end
  endtask : drive
  task automatic send(input logic [4:0] c);
    @(posedge clk);
    #1 level_valid = 1'b1;
    level_code = c;
    @(posedge clk);
    #1 level_valid = 1'b0;
  endtask : send
endmodule : ldm_host_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the dimming mode control block.
// Assumes shortened counts: delay 10, low 26, window 100, shutdown 250 cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, srst, pin, vld, en, wm, det;
  logic [4:0] code, lvl;
  logic [7:0] mv;
  int n_errors = 0;
  int check_count = 0;
  ldm_host_model host_u (.clk(clk), .ctrl_pin(pin), .level_valid(vld), .level_code(code));
  ldm_mode_ctrl #(.DELAY_CYC(10), .LOWDET_CYC(26), .WINDOW_CYC(100), .SHDN_CYC(250)) dut_u (
    .clk(clk), .srst(srst), .ctrl_pin(pin), .level_valid(vld), .level_code(code),
    .enabled_ff(en), .wire_mode_ff(wm), .detecting_ff(det), .level_ff(lvl),
    .feedback_reference_voltage_ff(mv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic off();
    host_u.drive(1'b0, 300);
    chk({7'h0, en}, 8'h0);
  endtask : off
  // Entry-like lows that start too early or finish too late must keep PWM.
  task automatic t_miss(input int hi);
    host_u.drive(1'b1, hi);
    host_u.drive(1'b0, 30);
    host_u.drive(1'b1, 200);
    chk({7'h0, wm}, 8'h0);
    off();
  endtask : t_miss
  task automatic t_pwm();
    host_u.drive(1'b1, 2500);
    chk({7'h0, wm}, 8'h0);
    chk({7'h0, en}, 8'h1);
    chk(mv, 8'hc8);
    off();
    repeat (200) begin
      host_u.drive(1'b1, 10);
      host_u.drive(1'b0, 10);
    end
    chk({7'h0, mv > 8'h55 && mv < 8'h73}, 8'h1);
    off();
  endtask : t_pwm
  task automatic t_wire();
    logic [4:0] cs [5];
    logic [7:0] ms [5];
    cs = '{5'h00, 5'h01, 5'h18, 5'h1f, 5'h0d};
    ms = '{8'h00, 8'h05, 8'h74, 8'hc8, 8'h2c};
    host_u.drive(1'b1, 12);
    chk({7'h0, det}, 8'h1);
    host_u.drive(1'b0, 30);
    chk({7'h0, wm}, 8'h1);
    chk({7'h0, det}, 8'h0);
    for (int i = 0; i < 5; i++) begin
      host_u.send(cs[i]);
      host_u.drive(1'b1, 3);
      chk({3'h0, lvl}, {3'h0, cs[i]});
      chk(mv, ms[i]);
    end
    off();
    host_u.send(5'h02);
    chk({3'h0, lvl}, 8'h0d);
    host_u.drive(1'b1, 300);
    chk({7'h0, wm}, 8'h0);
    chk({3'h0, lvl}, 8'h0d);
    off();
    @(posedge clk);
    #1 srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    chk({3'h0, lvl}, 8'h1f);
  endtask : t_wire
  initial begin
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk({3'h0, lvl}, 8'h1f);
    chk(mv, 8'h0);
    t_pwm();
    t_miss(3);
    t_miss(80);
    t_wire();
    complete_run();
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
